// >>> verilog/rae_defs.vh
`ifndef RAE_DEFS_VH
`define RAE_DEFS_VH
// Register byte offsets
`define RAE_A_DIAG 8'h00
`define RAE_A_DBUF 8'h04
`define RAE_A_XBUF 8'h08
`define RAE_A_DESCB 8'h0C
`define RAE_A_L1 8'h10
`define RAE_A_L2C0 8'h14
`define RAE_A_L2C1 8'h18
`define RAE_A_L2C2 8'h1C
`define RAE_A_L2C3 8'h20
`define RAE_A_MMIO 8'h24
`define RAE_A_CMPL 8'h28
`define RAE_A_DESC 8'h2C
`define RAE_A_ISTAT 8'h30
`define RAE_A_IMASK 8'h34
// Diagnostic register fields
`define RAE_DIAG_W 10
`define RAE_D_START 0
`define RAE_D_STPAR 1
`define RAE_D_HPAR 2
`define RAE_D_IBPAR 3
`define RAE_D_IDLI 4
`define RAE_D_IDL6 5
`define RAE_D_IDL7 6
`define RAE_D_TMO 7
`define RAE_D_B0 8
`define RAE_D_B1 9
// Level-1 status fields
`define RAE_L1_PAR 0
`define RAE_L1_TMO 1
// Level-2 status fields
`define RAE_L2_W 5
`define RAE_L2_IBPAR 0
`define RAE_L2_DTO 1
`define RAE_L2_IDLI 2
`define RAE_L2_IDL6 3
`define RAE_L2_IDL7 4
// Interrupt status fields
`define RAE_I_L2 0
`define RAE_I_L1 1
// MMIO command fields
`define RAE_M_RNW 4
`define RAE_M_BUSY 31
// Idle data bus level
`define RAE_IDLE_DATA 16'hFFFF
// Timing
`define RAE_DTACK_TO_NS 1000
`define RAE_CLK_NS 20
`endif

// >>> verilog/rae_top.v
`include "rae_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module rae_top #(
	parameter DTACK_TO_NS = `RAE_DTACK_TO_NS
) (
	input wire hclk, // System clock
	input wire hresetn, // Async reset, low
	input wire hsel, // Slave select
	input wire [31:0] haddr, // Byte address
	input wire [1:0] htrans, // Transfer type
	input wire hwrite, // Write flag
	input wire [2:0] hsize, // Transfer size
	input wire [31:0] hwdata, // Write data
	input wire hready, // Bus ready
	output reg [31:0] hrdata_ff, // Read data
	output reg hreadyout_ff, // Slave ready
	output reg hresp_ff, // Always OKAY
	output reg irq_ff, // Level-4 interrupt
	output reg pio_tmo_ff, // Host write timeout pulse
	output reg [3:0] chip_cs_ff, // Chip selects
	output reg chip_rnw_ff, // Read not write
	output reg [1:0] chip_rs_ff, // Chip register select
	output reg [15:0] chip_dout_ff, // Chip write data
	output reg [1:0] chip_dout_par_ff, // Write data parity
	output reg chip_dout_oe_ff, // Data bus drive
	input wire [15:0] chip_din, // Chip read data
	input wire [1:0] chip_din_par, // Read data parity
	input wire chip_dtack_n // Data acknowledge, low
);
	localparam [15:0] TO_CYC = DTACK_TO_NS / `RAE_CLK_NS;
	localparam [1:0] ST_IDLE = 2'b00;
	localparam [1:0] ST_WAIT = 2'b01;
	localparam [1:0] ST_END = 2'b10;

	// Odd parity per byte
	function [1:0] par16;
		input [15:0] d;
		begin
			par16 = {~^d[15:8], ~^d[7:0]};
		end
	endfunction

	// Lowest set error bit as code
	function [2:0] err_code;
		input [`RAE_L2_W-1:0] e;
		begin
			if (e[0])
				err_code = 3'h1;
			else if (e[1])
				err_code = 3'h2;
			else if (e[2])
				err_code = 3'h3;
			else if (e[3])
				err_code = 3'h4;
			else if (e[4])
				err_code = 3'h5;
			else
				err_code = 3'h0;
		end
	endfunction

	reg [7:0] a_addr_ff;
	reg a_wr_ff;
	reg a_rd_ff;
	reg [`RAE_DIAG_W-1:0] diag_ff;
	reg [15:0] dbuf_ff;
	reg [1:0] dbuf_par_ff;
	reg [7:0] xbuf_ff;
	reg xbuf_par_ff;
	reg [15:0] descb_ff;
	reg [1:0] descb_par_ff;
	reg [1:0] l1_ff;
	reg [`RAE_L2_W-1:0] l2_ff [0:3];
	reg [1:0] istat_ff;
	reg [1:0] imask_ff;
	reg [31:0] cmpl_ff;
	reg [15:0] desc_ff;
	reg [1:0] st_ff;
	reg [15:0] cnt_ff;
	reg [1:0] chip_ff;
	reg [`RAE_L2_W-1:0] merr_ff;
	reg mstart_ff;
	reg dtn_s1_ff;
	reg dtn_ff;
	reg [15:0] din_s1_ff;
	reg [15:0] din_ff;
	reg [1:0] dpar_s1_ff;
	reg [1:0] dpar_ff;
	integer i;

	// Address phase capture
	wire a_take = hsel & hready & htrans[1];
	wire wr_do = a_wr_ff;
	wire rd_do = a_rd_ff;
	wire [1:0] bsel = {diag_ff[`RAE_D_B1], diag_ff[`RAE_D_B0]};
	wire armed = diag_ff[`RAE_D_START];
	// Any non-diagnostic access counts as the next command
	wire is_cmd = (a_addr_ff != `RAE_A_DIAG);
	wire f_st = armed & diag_ff[`RAE_D_STPAR] & (|bsel);
	wire f_hp = armed & diag_ff[`RAE_D_HPAR] & (|bsel);
	wire wr_cmd = wr_do & is_cmd;
	wire rd_cmd = rd_do & is_cmd;
	wire wr_block = wr_cmd & f_hp;
	wire wr_ok = wr_do & ~wr_block;
	wire [1:0] st_flip = f_st ? bsel : 2'b00;
	wire [1:0] wpar = par16(hwdata[15:0]) ^ st_flip;
	wire mm_go = wr_ok & (a_addr_ff == `RAE_A_MMIO) & (st_ff == ST_IDLE);

	// Read mux and stored parity check
	reg [31:0] rdata;
	reg rd_bad;
	always @*
	begin
		rdata = 32'h0000_0000;
		rd_bad = 1'b0;
		if (a_addr_ff == `RAE_A_DIAG)
			rdata[`RAE_DIAG_W-1:0] = diag_ff;
		else if (a_addr_ff == `RAE_A_DBUF)
		begin
			rdata[15:0] = dbuf_ff;
			rd_bad = (dbuf_par_ff != par16(dbuf_ff));
		end
		else if (a_addr_ff == `RAE_A_XBUF)
		begin
			rdata[15:8] = xbuf_ff;
			rd_bad = (xbuf_par_ff != ~^xbuf_ff);
		end
		else if (a_addr_ff == `RAE_A_DESCB)
		begin
			rdata[15:0] = descb_ff;
			rd_bad = (descb_par_ff != par16(descb_ff));
		end
		else if (a_addr_ff == `RAE_A_L1)
			rdata[1:0] = l1_ff;
		else if (a_addr_ff == `RAE_A_L2C0)
			rdata[`RAE_L2_W-1:0] = l2_ff[0];
		else if (a_addr_ff == `RAE_A_L2C1)
			rdata[`RAE_L2_W-1:0] = l2_ff[1];
		else if (a_addr_ff == `RAE_A_L2C2)
			rdata[`RAE_L2_W-1:0] = l2_ff[2];
		else if (a_addr_ff == `RAE_A_L2C3)
			rdata[`RAE_L2_W-1:0] = l2_ff[3];
		else if (a_addr_ff == `RAE_A_MMIO)
			rdata[`RAE_M_BUSY] = (st_ff != ST_IDLE);
		else if (a_addr_ff == `RAE_A_CMPL)
			rdata = cmpl_ff;
		else if (a_addr_ff == `RAE_A_DESC)
			rdata[15:0] = desc_ff;
		else if (a_addr_ff == `RAE_A_ISTAT)
			rdata[1:0] = istat_ff;
		else if (a_addr_ff == `RAE_A_IMASK)
			rdata[1:0] = imask_ff;
	end

	// Level-2 read clear, per chip
	reg [3:0] l2_clr;
	always @*
	begin
		l2_clr = 4'h0;
		if (rd_do)
		begin
			if (a_addr_ff == `RAE_A_L2C0)
				l2_clr[0] = 1'b1;
			else if (a_addr_ff == `RAE_A_L2C1)
				l2_clr[1] = 1'b1;
			else if (a_addr_ff == `RAE_A_L2C2)
				l2_clr[2] = 1'b1;
			else if (a_addr_ff == `RAE_A_L2C3)
				l2_clr[3] = 1'b1;
		end
	end

	// MMIO completion and checkers
	wire m_ack = ~dtn_ff & ~(mstart_ff & diag_ff[`RAE_D_TMO]);
	wire m_tmo = (cnt_ff >= TO_CYC - 16'h0001);
	wire m_end = (st_ff == ST_WAIT) & (m_ack | m_tmo);
	wire [1:0] ib_flip = (mstart_ff & diag_ff[`RAE_D_IBPAR]) ? bsel : 2'b00;
	wire ib_err = chip_rnw_ff & m_ack & ((par16(din_ff) ^ ib_flip) != dpar_ff);
	wire idl_i = mstart_ff & diag_ff[`RAE_D_IDLI];
	wire idl_6 = mstart_ff & diag_ff[`RAE_D_IDL6];
	wire idl_7 = mstart_ff & diag_ff[`RAE_D_IDL7];
	wire [`RAE_L2_W-1:0] m_err = {idl_7, idl_6, idl_i, ~m_ack, ib_err};
	wire m_frc = mstart_ff & (|diag_ff[`RAE_D_TMO:`RAE_D_IBPAR]);
	wire l1_set_p = (rd_cmd & (rd_bad | f_hp)) | wr_block;
	wire l2_ev = (st_ff == ST_END) & (|merr_ff);
	// Start clears once the armed force has been spent
	wire st_clr = ((wr_cmd | rd_cmd) & (f_st | f_hp)) | (m_end & m_frc);

	// Bus slave: writes take no wait, reads take one
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			a_addr_ff <= 8'h00;
			a_wr_ff <= 1'b0;
			a_rd_ff <= 1'b0;
			hreadyout_ff <= 1'b1;
			hrdata_ff <= 32'h0000_0000;
			hresp_ff <= 1'b0;
		end
		else
		begin
			a_wr_ff <= a_take & hwrite;
			a_rd_ff <= a_take & ~hwrite;
			if (a_take)
				a_addr_ff <= haddr[7:0];
			hreadyout_ff <= ~(a_take & ~hwrite);
			if (rd_do)
				hrdata_ff <= rdata;
			hresp_ff <= 1'b0;
		end
	end

	// Diagnostic register and parity-holding buffers
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			diag_ff <= 10'h000;
			dbuf_ff <= 16'h0000;
			dbuf_par_ff <= 2'b11;
			xbuf_ff <= 8'h00;
			xbuf_par_ff <= 1'b1;
			descb_ff <= 16'h0000;
			descb_par_ff <= 2'b11;
		end
		else
		begin
			if (wr_do & ~is_cmd)
				diag_ff <= hwdata[`RAE_DIAG_W-1:0];
			else if (st_clr)
				diag_ff[`RAE_D_START] <= 1'b0;
			// Only these three keep parity; others drop it
			if (wr_ok & (a_addr_ff == `RAE_A_DBUF))
			begin
				dbuf_ff <= hwdata[15:0];
				dbuf_par_ff <= wpar;
			end
			if (wr_ok & (a_addr_ff == `RAE_A_XBUF))
			begin
				xbuf_ff <= hwdata[15:8];
				xbuf_par_ff <= wpar[1];
			end
			if (wr_ok & (a_addr_ff == `RAE_A_DESCB))
			begin
				descb_ff <= hwdata[15:0];
				descb_par_ff <= wpar;
			end
		end
	end

	// Status, interrupt and timeout logging; set wins over clear
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			l1_ff <= 2'b00;
			istat_ff <= 2'b00;
			imask_ff <= 2'b00;
			irq_ff <= 1'b0;
			pio_tmo_ff <= 1'b0;
			for (i = 0; i < 4; i = i + 1)
				l2_ff[i] <= 5'h00;
		end
		else
		begin
			pio_tmo_ff <= wr_block;
			l1_ff[`RAE_L1_PAR] <= l1_set_p | (l1_ff[`RAE_L1_PAR]
				& ~(wr_ok & (a_addr_ff == `RAE_A_L1) & hwdata[`RAE_L1_PAR]));
			l1_ff[`RAE_L1_TMO] <= wr_block | (l1_ff[`RAE_L1_TMO]
				& ~(wr_ok & (a_addr_ff == `RAE_A_L1) & hwdata[`RAE_L1_TMO]));
			for (i = 0; i < 4; i = i + 1)
			begin
				if (l2_ev & (chip_ff == i[1:0]))
					l2_ff[i] <= merr_ff | (l2_clr[i] ? 5'h00 : l2_ff[i]);
				else if (l2_clr[i])
					l2_ff[i] <= 5'h00;
			end
			if (wr_ok & (a_addr_ff == `RAE_A_IMASK))
				imask_ff <= hwdata[1:0];
			istat_ff[`RAE_I_L2] <= l2_ev | (istat_ff[`RAE_I_L2]
				& ~(wr_ok & (a_addr_ff == `RAE_A_ISTAT) & hwdata[`RAE_I_L2]));
			istat_ff[`RAE_I_L1] <= l1_set_p | (istat_ff[`RAE_I_L1]
				& ~(wr_ok & (a_addr_ff == `RAE_A_ISTAT) & hwdata[`RAE_I_L1]));
			irq_ff <= |(istat_ff & imask_ff);
		end
	end

	// Pin synchronisers
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dtn_s1_ff <= 1'b1;
			dtn_ff <= 1'b1;
			din_s1_ff <= 16'h0000;
			din_ff <= 16'h0000;
			dpar_s1_ff <= 2'b00;
			dpar_ff <= 2'b00;
		end
		else
		begin
			dtn_s1_ff <= chip_dtack_n;
			dtn_ff <= dtn_s1_ff;
			din_s1_ff <= chip_din;
			din_ff <= din_s1_ff;
			dpar_s1_ff <= chip_din_par;
			dpar_ff <= dpar_s1_ff;
		end
	end

	// MMIO sequencer with acknowledge timer
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_ff <= ST_IDLE;
			cnt_ff <= 16'h0000;
			chip_ff <= 2'b00;
			merr_ff <= 5'h00;
			mstart_ff <= 1'b0;
			chip_cs_ff <= 4'h0;
			chip_rnw_ff <= 1'b1;
			chip_rs_ff <= 2'b00;
			chip_dout_ff <= `RAE_IDLE_DATA;
			chip_dout_par_ff <= 2'b11;
			chip_dout_oe_ff <= 1'b0;
			cmpl_ff <= 32'h0000_0000;
			desc_ff <= 16'h0000;
		end
		else
		begin
			case (st_ff)
			ST_IDLE:
			begin
				cnt_ff <= 16'h0000;
				if (mm_go)
				begin
					st_ff <= ST_WAIT;
					chip_ff <= hwdata[1:0];
					chip_rs_ff <= hwdata[3:2];
					chip_rnw_ff <= hwdata[`RAE_M_RNW];
					chip_cs_ff <= 4'h1 << hwdata[1:0];
					chip_dout_ff <= hwdata[31:16];
					chip_dout_par_ff <= par16(hwdata[31:16]);
					chip_dout_oe_ff <= ~hwdata[`RAE_M_RNW];
					mstart_ff <= armed;
				end
			end
			ST_WAIT:
			begin
				cnt_ff <= cnt_ff + 16'h0001;
				if (m_end)
				begin
					st_ff <= ST_END;
					merr_ff <= m_err;
					chip_cs_ff <= 4'h0;
					chip_dout_oe_ff <= 1'b0;
					cmpl_ff <= {din_ff, 8'h00, chip_rnw_ff, chip_ff, m_err};
				end
			end
			ST_END:
			begin
				st_ff <= ST_IDLE;
				mstart_ff <= 1'b0;
				if (|merr_ff)
					desc_ff <= descb_ff + {11'h000, chip_ff, err_code(merr_ff)};
			end
			default:
				st_ff <= ST_IDLE;
			endcase
		end
	end
endmodule // rae_top
`default_nettype wire

// >>> testbench/rae_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module rae_top_sva #(
	parameter DTACK_TO_NS = 1000
) (
	input wire logic hclk, // Clock
	input wire logic hresetn, // Reset, low
	input wire logic hsel, // Select
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write flag
	input wire logic hready, // Bus ready
	input wire logic hreadyout_ff, // Slave ready
	input wire logic hresp_ff, // Response
	input wire logic pio_tmo_ff, // Write refused
	input wire logic [3:0] chip_cs_ff, // Chip selects
	input wire logic chip_rnw_ff, // Read flag
	input wire logic [1:0] chip_rs_ff, // Register select
	input wire logic [15:0] chip_dout_ff, // Write data
	input wire logic [1:0] chip_dout_par_ff, // Write parity
	input wire logic chip_dout_oe_ff // Data drive
);
	// Timeout span plus sync slack
	localparam int TO_MAX = DTACK_TO_NS / 20 + 8;
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	chk_resp_okay: assert property (hresp_ff == 1'b0)
		else $error("response not OKAY");
	chk_read_wait: assert property (hsel && hready && htrans[1] && !hwrite
		|=> !hreadyout_ff ##1 hreadyout_ff) else $error("read wait wrong");
	chk_write_fast: assert property (hsel && hready && htrans[1] && hwrite
		|=> hreadyout_ff) else $error("write stalled");
	chk_tmo_pulse: assert property (pio_tmo_ff |=> !pio_tmo_ff)
		else $error("timeout pulse too long");
	chk_cs_onehot: assert property (chip_cs_ff != 4'h0 |-> $onehot(chip_cs_ff))
		else $error("chip select not one-hot");
	chk_mmio_bound: assert property ($rose(|chip_cs_ff)
		|-> ##[1:TO_MAX] chip_cs_ff == 4'h0) else $error("access not ended");
	chk_oe_write: assert property (chip_dout_oe_ff |-> !chip_rnw_ff && |chip_cs_ff)
		else $error("data driven outside write");
	chk_cs_steady: assert property (|chip_cs_ff && |$past(chip_cs_ff)
		|-> $stable(chip_cs_ff) && $stable(chip_rs_ff) && $stable(chip_rnw_ff))
		else $error("access changed midway");
	// Driven write data must carry odd parity per byte
	chk_dout_parity: assert property (chip_dout_oe_ff
		|-> chip_dout_par_ff == {~^chip_dout_ff[15:8], ~^chip_dout_ff[7:0]})
		else $error("write parity wrong");
endmodule // rae_top_sva
bind rae_top rae_top_sva #(.DTACK_TO_NS(DTACK_TO_NS)) u_sva (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hreadyout_ff(hreadyout_ff), .hresp_ff(hresp_ff),
	.pio_tmo_ff(pio_tmo_ff), .chip_cs_ff(chip_cs_ff), .chip_rnw_ff(chip_rnw_ff),
	.chip_rs_ff(chip_rs_ff), .chip_dout_ff(chip_dout_ff),
	.chip_dout_par_ff(chip_dout_par_ff), .chip_dout_oe_ff(chip_dout_oe_ff)
);
`default_nettype wire

// >>> testbench/rae_chip_model.sv
`timescale 1ns/1ps
`default_nettype none
module rae_chip_model (
	input wire logic hclk, // Clock
	input wire logic [3:0] cs, // Selects
	input wire logic rnw, // Read flag
	input wire logic [15:0] dout, // Write data
	input wire logic slow, // Late answer
	output logic [15:0] din = 16'h5A5A, // Read data
	output logic [1:0] din_par = 2'h0, // Read parity
	output logic dtack_n = 1'b1 // Acknowledge, low
);
	logic [15:0] mem = 16'h1234;
	logic [4:0] cnt = 5'h0;
	// Undriven bus toggles data and parity, so stale data passes parity only every other cycle
	always @(posedge hclk)
	begin
		cnt <= (cs == 4'h0) ? 5'h0 : cnt + 5'h1;
		if (cs != 4'h0 && cnt == (slow ? 5'h14 : 5'h1))
		begin
			dtack_n <= 1'b0;
			din <= mem;
			din_par <= {~^mem[15:8], ~^mem[7:0]};
			if (!rnw)
				mem <= dout;
		end
		else if (cs == 4'h0 || dtack_n)
		begin
			dtack_n <= 1'b1;
			din <= ~din;
			din_par <= ~din_par;
		end
	end
endmodule // rae_chip_model
`default_nettype wire

// >>> testbench/rae_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "rae_defs.vh"
module rae_top_test;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic slow = 1'b0;
	logic hreadyout_ff, irq_ff, chip_rnw_ff, chip_dtack_n, pio_tmo_ff;
	logic [1:0] chip_rs_ff;
	int tmo_cnt = 0;
	logic [3:0] chip_cs_ff;
	logic [1:0] chip_dout_par_ff, chip_din_par;
	logic [15:0] chip_dout_ff, chip_din;
	logic [31:0] hrdata_ff, q;
	logic [7:0] ra[3] = '{`RAE_A_DBUF, `RAE_A_XBUF, `RAE_A_DESCB};
	int l2b[8] = '{0, 0, 0, 0, 2, 3, 4, 1};
	int fail_count = 0;
	int samples_checked = 0;
	int b, r, k, c, e;
	always #10 hclk = ~hclk;
	rae_top #(.DTACK_TO_NS(200)) DUT (
		.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout_ff),
		.hrdata_ff(hrdata_ff), .hreadyout_ff(hreadyout_ff), .hresp_ff(), .irq_ff(irq_ff),
		.pio_tmo_ff(pio_tmo_ff), .chip_cs_ff(chip_cs_ff), .chip_rnw_ff(chip_rnw_ff),
		.chip_rs_ff(chip_rs_ff),
		.chip_dout_ff(chip_dout_ff), .chip_dout_par_ff(chip_dout_par_ff),
		.chip_dout_oe_ff(), .chip_din(chip_din), .chip_din_par(chip_din_par),
		.chip_dtack_n(chip_dtack_n));
	rae_chip_model u_chip (.hclk(hclk), .cs(chip_cs_ff), .rnw(chip_rnw_ff),
		.dout(chip_dout_ff), .slow(slow), .din(chip_din), .din_par(chip_din_par),
		.dtack_n(chip_dtack_n));
	// Count refused-write pulses; a single cycle is easy to miss
	always @(posedge hclk)
		if (pio_tmo_ff === 1'b1)
			tmo_cnt <= tmo_cnt + 1;
	// One bus transfer; read data lands in q
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		@(posedge hclk);
		while (hreadyout_ff !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout_ff !== 1'b1) @(posedge hclk);
		q = hrdata_ff;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(q, exp);
	endtask
	// Poll busy, then allow the status and irq pipeline to settle
	task automatic mwait;
		q = 32'h80000000;
		while (q[31] !== 1'b0) xfer(1'b0, `RAE_A_MMIO, 32'h0);
		repeat (4) @(posedge hclk);
	endtask
	task automatic close_out;
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rc(8'h3C, 32'h0);
		xfer(1'b1, `RAE_A_IMASK, 32'h1);
		xfer(1'b1, `RAE_A_DIAG, 32'h306);
		xfer(1'b1, `RAE_A_XBUF, 32'hFFFF);
		rc(`RAE_A_XBUF, 32'hFF00);
		rc(`RAE_A_L1, 32'h0);
		rc(`RAE_A_DIAG, 32'h306);
		// Forced host parity on writes must drop them
		for (b = 1; b < 4; b++)
		begin
			xfer(1'b1, `RAE_A_DBUF, 32'h1234);
			xfer(1'b1, `RAE_A_DIAG, 32'h5 | b << 8);
			xfer(1'b1, `RAE_A_DBUF, 32'hABCD);
			rc(`RAE_A_DBUF, 32'h1234);
			rc(`RAE_A_DIAG, 32'h4 | b << 8);
			rc(`RAE_A_L1, 32'h3);
			chk(tmo_cnt, b);
			chk({31'h0, irq_ff}, 32'h0);
			xfer(1'b1, `RAE_A_L1, 32'h3);
			xfer(1'b1, `RAE_A_ISTAT, 32'h3);
		end
		// Stored bad parity shows only when read back
		for (r = 0; r < 3; r++)
			for (b = (r == 1) ? 2 : 1; b < 4; b++)
			begin
				xfer(1'b1, `RAE_A_DIAG, 32'h3 | b << 8);
				xfer(1'b1, ra[r], 32'h5A5A);
				rc(`RAE_A_DIAG, 32'h2 | b << 8);
				rc(`RAE_A_L1, 32'h0);
				xfer(1'b0, ra[r], 32'h0);
				rc(`RAE_A_L1, 32'h1);
				xfer(1'b1, `RAE_A_L1, 32'h3);
				xfer(1'b1, `RAE_A_ISTAT, 32'h3);
			end
		xfer(1'b1, `RAE_A_DBUF, 32'h1234);
		for (b = 1; b < 4; b++)
		begin
			xfer(1'b1, `RAE_A_DIAG, 32'h5 | b << 8);
			xfer(1'b0, `RAE_A_DBUF, 32'h0);
			rc(`RAE_A_DIAG, 32'h4 | b << 8);
			rc(`RAE_A_L1, 32'h1);
			xfer(1'b1, `RAE_A_L1, 32'h3);
		end
		// Each checker forced on an MMIO read of chip k mod 4
		xfer(1'b1, `RAE_A_DESCB, 32'h100);
		for (k = 3; k < 8; k++)
		begin
			c = k % 4;
			e = l2b[k];
			xfer(1'b1, `RAE_A_DIAG, 32'h301 | 1 << k);
			xfer(1'b1, `RAE_A_MMIO, 32'h18 | c);
			mwait;
			chk({31'h0, irq_ff}, 32'h1);
			xfer(1'b0, `RAE_A_CMPL, 32'h0);
			chk(q & 32'hFF, 32'h80 | c << 5 | 1 << e);
			chk({30'h0, chip_rs_ff}, 32'h2);
			rc(`RAE_A_DESC, 32'h100 + (c << 3) + e + 1);
			rc(8'(`RAE_A_L2C0 + 4 * c), 1 << e);
			xfer(1'b1, `RAE_A_ISTAT, 32'h1);
			rc(8'(`RAE_A_L2C0 + 4 * c), 32'h0);
			rc(`RAE_A_DIAG, 32'h300 | 1 << k);
			chk({31'h0, irq_ff}, 32'h0);
		end
		xfer(1'b1, `RAE_A_DIAG, 32'hF8);
		xfer(1'b1, `RAE_A_MMIO, 32'hBEEF0001);
		mwait;
		xfer(1'b1, `RAE_A_MMIO, 32'h11);
		mwait;
		rc(`RAE_A_CMPL, 32'hBEEF00A0);
		rc(`RAE_A_L2C1, 32'h0);
		slow <= 1'b1;
		xfer(1'b1, `RAE_A_MMIO, 32'h12);
		mwait;
		rc(`RAE_A_L2C2, 32'h2);
		chk(tmo_cnt, 3);
		close_out;
	end
	// Cut a hang short
	initial
	begin
		repeat (20000) @(posedge hclk);
		fail_count++;
		close_out;
	end
endmodule // rae_top_test
`default_nettype wire
